// ---- pkg/hbis_pkg.sv ----
// Shared constants for the host bus interface select block.
// Assumes a single 25 MHz clock shared by both ends of the link.
package hbis_pkg;

  // ==========================================================================
  // Widths
  localparam int ADDR_W = 7;   // Register address width
  localparam int DATA_W = 8;   // Register data width
  localparam int MODE_W = 3;   // Strap and mode width

  // ==========================================================================
  // Interface mode codes
  localparam logic [2:0] MODE_OFF    = 3'h0;  // Interface disabled
  localparam logic [2:0] MODE_EPROM  = 3'h1;  // Boot load from EPROM
  localparam logic [2:0] MODE_MUX    = 3'h2;  // Multiplexed address/data bus
  localparam logic [2:0] MODE_PAR_B  = 3'h3;  // Strobe-style parallel bus
  localparam logic [2:0] MODE_PAR_A  = 3'h4;  // Select/direction/ack parallel bus
  localparam logic [2:0] MODE_SERIAL = 3'h5;  // Serial host interface

  // ==========================================================================
  // Register map and bus encodings
  localparam logic [6:0] MODE_REG_ADDR = 7'h7f;  // Mode override register
  localparam logic [7:0] MODE_RST      = 8'h00;  // Register reset value
  localparam logic       DIR_READ      = 1'b1;   // Direction level for a read

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 40;   // 25 MHz clock
  localparam int RD_RD_NS      = 40;   // Longest read data delay, read after read
  localparam int RD_WR_NS      = 192;  // Longest read data delay, read after write
  localparam int WR_GAP_NS     = 160;  // Least gap after a write
  localparam int RD_GAP_NS     = 15;   // Least gap between reads
  // Longest times round down, least times round up, never below one cycle
  localparam int RD_RD_CYC  = (RD_RD_NS / CLK_PERIOD_NS) < 1 ? 1 : RD_RD_NS / CLK_PERIOD_NS;
  localparam int RD_WR_CYC  = (RD_WR_NS / CLK_PERIOD_NS) < 1 ? 1 : RD_WR_NS / CLK_PERIOD_NS;
  localparam int WR_GAP_CYC = (WR_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_GAP_CYC = (RD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_ACK_CYC = 1;       // Write acknowledge delay
  localparam int STRAP_SYNC_CYC = 2;   // Cycles for straps to cross the synchroniser
  localparam int EPROM_WAIT_CYC = 8;   // EPROM round trip, both ends' syncs included
  localparam int EPROM_WORDS    = 128; // Words loaded at boot

endpackage

// ---- pkg/hbis_if.sv ----
// Link between the timing device's host port and its host / boot EPROM.
// Assumes each end drives its own copy of a shared pin plus an enable.
interface hbis_if;

  // ==========================================================================
  // Host bus pins
  logic [6:0] addr;              // Register address from host
  logic       direction_select;  // High for read, low for write
  logic       select_n;          // Access frame, active low
  logic [7:0] host_data;         // Host copy of the data bus
  logic       host_data_oe;      // Host drives the data bus
  logic [7:0] dev_data;          // Device copy of the data bus
  logic       dev_data_oe;       // Device drives the data bus
  logic       ack_o;             // Device copy of transfer_ack
  logic       ack_oe;            // Device drives transfer_ack
  logic [7:0] data_bus;          // Resolved data bus
  logic       transfer_ack;      // Resolved acknowledge, pulled high

  // ==========================================================================
  // Boot EPROM pins
  logic       eprom_rd;          // Device requests an EPROM word
  logic [6:0] eprom_addr;        // EPROM word index
  logic [7:0] eprom_data;        // EPROM word returned
  logic       eprom_sel_n;       // EPROM select, driven by the host

  // Released wires float to the pulled-up level
  assign data_bus     = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'hff);
  assign transfer_ack = ack_oe ? ack_o : 1'b1;

  modport dev (
    input  addr, direction_select, select_n, data_bus, eprom_data, eprom_sel_n,
    output dev_data, dev_data_oe, ack_o, ack_oe, eprom_rd, eprom_addr
  );

  modport host (
    input  data_bus, transfer_ack, eprom_rd, eprom_addr,
    output addr, direction_select, select_n, host_data, host_data_oe,
    output eprom_data, eprom_sel_n
  );

endinterface

// ---- hw/hbis_host.sv ----
// Host end: runs select/direction/ack accesses and serves boot EPROM reads.
// Assumes the device end on the far side of hbis_if; pins are re-synchronised.
module hbis_host (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  hbis_if.host                        bus,
  input  wire logic                   req_valid,    // Access request
  input  wire logic                   req_write,    // High for a write
  input  wire logic [6:0]             req_addr,     // Register address
  input  wire logic [7:0]             req_wdata,    // Write data
  input  wire logic [7:0]             rom_data,     // EPROM content at rom_addr
  output logic                        req_ready,    // Idle, request taken
  output logic                        rsp_valid,    // Access finished, pulse
  output logic [7:0]                  rsp_data,     // Read data, or the write data for a write
  output logic [6:0]                  rom_addr,     // EPROM word wanted
  output logic                        rom_rd        // EPROM read in progress
);

  // ==========================================================================
  // Types and state
  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,  // Waiting for a request
    H_SETUP = 4'b0010,  // Address and direction settle
    H_WAIT  = 4'b0100,  // Select low, waiting for acknowledge
    H_GAP   = 4'b1000   // Select high, spacing to next access
  } hbis_host_st_e;

  hbis_host_st_e st_q;
  logic [16:0]   s1_q, s2_q;   // Pin synchronisers
  logic [7:0]    cnt_q;        // Gap counter
  logic          seen_hi_q;    // Acknowledge seen high in this access
  logic          was_wr_q;     // Current access is a write
  logic [6:0]    addr_q;
  logic          dir_q, sel_n_q, oe_q, esel_n_q;
  logic [7:0]    wdat_q, edat_q;

  // ==========================================================================
  // Synchronised inputs
  wire       ack_s  = s2_q[16];
  wire [7:0] dat_s  = s2_q[15:8];
  wire       erd_s  = s2_q[7];
  wire [6:0] eadr_s = s2_q[6:0];
  wire       take   = (st_q == H_IDLE) && req_valid;
  wire       done   = (st_q == H_WAIT) && seen_hi_q && !ack_s;

  // Two flip-flops on every pin from the device
  always_ff @(posedge clk) begin
    s1_q <= {bus.transfer_ack, bus.data_bus, bus.eprom_rd, bus.eprom_addr};
    s2_q <= s1_q;
  end

  // EPROM responder, serves only while the host bus is quiet
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rom_addr <= 7'h00;
      rom_rd   <= 1'b0;
      edat_q   <= 8'h00;
      esel_n_q <= 1'b1;
    end else begin
      esel_n_q <= (st_q != H_IDLE) || req_valid;  // R6
      rom_addr <= eadr_s;
      rom_rd   <= erd_s;
      edat_q   <= rom_data;
    end
  end

  // Access sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q      <= H_IDLE;
      cnt_q     <= 8'h00;
      seen_hi_q <= 1'b0;
      was_wr_q  <= 1'b0;
      addr_q    <= 7'h00;
      dir_q     <= hbis_pkg::DIR_READ;
      sel_n_q   <= 1'b1;
      oe_q      <= 1'b0;
      wdat_q    <= 8'h00;
      req_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      case (st_q)
        H_IDLE: begin
          oe_q <= 1'b0;
          if (take) begin
            // Address, direction and data before select falls
            addr_q    <= req_addr;  // R8
            dir_q     <= req_write ? ~hbis_pkg::DIR_READ : hbis_pkg::DIR_READ;  // R7
            wdat_q    <= req_wdata;  // R13
            oe_q      <= req_write;
            was_wr_q  <= req_write;
            req_ready <= 1'b0;
            st_q      <= H_SETUP;
          end
        end
        H_SETUP: begin
          sel_n_q   <= 1'b0;  // R7
          seen_hi_q <= 1'b0;
          st_q      <= H_WAIT;
        end
        H_WAIT: begin
          // Stale low from the last access is skipped by seen_hi
          if (ack_s) begin
            seen_hi_q <= 1'b1;
          end
          if (done) begin
            sel_n_q   <= 1'b1;  // R9
            rsp_valid <= 1'b1;
            rsp_data  <= was_wr_q ? wdat_q : dat_s;
            cnt_q     <= was_wr_q ? 8'(hbis_pkg::WR_GAP_CYC) : 8'(hbis_pkg::RD_GAP_CYC);  // R10 R11
            st_q      <= H_GAP;
          end
        end
        H_GAP: begin
          // Address, direction and data stay put after select rises
          if (cnt_q <= 8'h01) begin  // R8 R13
            req_ready <= 1'b1;
            st_q      <= H_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  assign bus.addr             = addr_q;
  assign bus.direction_select = dir_q;
  assign bus.select_n         = sel_n_q;
  assign bus.host_data        = wdat_q;
  assign bus.host_data_oe     = oe_q;
  assign bus.eprom_data       = edat_q;
  assign bus.eprom_sel_n      = esel_n_q;

endmodule

// ---- hw/hbis_dev.sv ----
// Device end: strap mode capture, EPROM boot load, and the
// select/direction/ack register access port with its register store.
// Assumes the host end on hbis_if; all pins pass two flip-flops first.

// Contract
// [R1] Straps 4,3,2 select the three parallel buses
// [R2] Strap 5 serial, 1 EPROM, others disabled
// [R3] Straps sampled once after reset only
// [R4] EPROM mode loads registers automatically at boot
// [R5] Writing address 7F replaces the mode
// [R6] Host drives EPROM select to avoid collisions
// [R7] Select frames access, direction line sets type
// [R8] Host holds address, direction across select
// [R9] Host keeps select low until ack falls
// [R10] Host waits 160 ns after a write
// [R11] Host waits 15 ns between reads
// [R12] Read data within 40 ns, 192 after write; the device counts 1 and 4 cycles from select seen through its synchroniser
// [R13] Host holds write data around select rise
// [R14] Drive data only in reads, release after select
// [R15] Ignore bus while disabled or booting
module hbis_dev #(
  parameter int EPROM_WORDS = hbis_pkg::EPROM_WORDS,     // Words copied at boot
  parameter int EPROM_WAIT  = hbis_pkg::EPROM_WAIT_CYC   // Cycles per EPROM word
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  hbis_if.dev                         bus,
  input  wire logic [2:0]             host_mode_straps,  // Mode strap pins
  output logic [2:0]                  mode,              // Current interface mode
  output logic                        boot_busy,         // Strap capture or load running
  output logic                        cfg_wr,            // Register written, pulse
  output logic [6:0]                  cfg_addr,          // Address of that write
  output logic [7:0]                  cfg_data           // Data of that write
);

  // ==========================================================================
  // Types and state
  typedef enum logic [4:0] {
    S_STRAP = 5'b00001,  // Straps crossing the synchroniser
    S_EROM  = 5'b00010,  // Copying EPROM words into registers
    S_IDLE  = 5'b00100,  // Waiting for select to fall
    S_LAT   = 5'b01000,  // Access latency, ack high
    S_DONE  = 5'b10000   // Ack low, waiting for select to rise
  } hbis_dev_st_e;

  hbis_dev_st_e st_q;
  logic [28:0]  s1_q, s2_q;        // Pin synchronisers
  logic         sel_prev_q;        // Select one cycle back
  logic [7:0]   dat_prev_q;        // Data bus one cycle back
  logic [7:0]   cnt_q;             // Latency / wait counter
  logic [7:0]   idx_q;             // EPROM word index
  logic [7:0]   regs_q [0:127];    // Register store
  logic [6:0]   acc_addr_q;        // Latched access address
  logic         acc_rd_q;          // Latched access is a read
  logic         last_wr_q;         // Previous access was a write
  logic         ack_q, ack_oe_q;   // Acknowledge pin copy and enable
  logic [7:0]   dout_q;            // Read data pin copy
  logic         dout_oe_q;         // Read data enable
  logic         erd_q;             // EPROM read request
  logic [2:0]   mode_q;            // Interface mode

  // ==========================================================================
  // Synchronised pins
  wire [2:0] strap_s = s2_q[28:26];
  wire       sel_s   = s2_q[25];
  wire       dir_s   = s2_q[24];
  wire [6:0] addr_s  = s2_q[23:17];
  wire [7:0] dat_s   = s2_q[16:9];
  wire [7:0] edat_s  = s2_q[8:1];
  wire       egnt_s  = !s2_q[0];

  // Two flip-flops on every pin; the first stage is read only by the second
  always_ff @(posedge clk) begin
    s1_q <= {host_mode_straps, bus.select_n, bus.direction_select, bus.addr,
             bus.data_bus, bus.eprom_data, bus.eprom_sel_n};
    s2_q <= s1_q;
  end

  // ==========================================================================
  // Mode decode
  wire mode_par_a  = (mode_q == hbis_pkg::MODE_PAR_A);   // R1
  wire mode_par_b  = (mode_q == hbis_pkg::MODE_PAR_B);   // R1
  wire mode_mux    = (mode_q == hbis_pkg::MODE_MUX);     // R1
  wire mode_serial = (mode_q == hbis_pkg::MODE_SERIAL);  // R2
  wire strap_erom  = (strap_s == hbis_pkg::MODE_EPROM);  // R2
  // Only the select/direction/ack bus has an engine here; other live modes idle
  wire mode_live   = mode_par_a | mode_par_b | mode_mux | mode_serial;  // R2

  // ==========================================================================
  // Access decode
  wire sel_fall = sel_prev_q && !sel_s;
  wire sel_rise = !sel_prev_q && sel_s;
  // Accesses are only taken in idle and in MODE_PAR_A, so booting or disabled ignores the bus
  wire take     = (st_q == S_IDLE) && mode_par_a && sel_fall;  // R15
  wire lat_end  = (st_q == S_LAT) && (cnt_q <= 8'h01);
  wire erom_wr  = (st_q == S_EROM) && erd_q && egnt_s && (cnt_q <= 8'h01);  // R4
  wire bus_wr   = (st_q == S_DONE) && sel_rise && !acc_rd_q;  // R7
  wire wr_en    = erom_wr | bus_wr;
  wire [6:0] wr_addr = erom_wr ? idx_q[6:0] : acc_addr_q;
  wire [7:0] wr_data = erom_wr ? edat_s : dat_prev_q;
  wire mode_wr  = wr_en && (wr_addr == hbis_pkg::MODE_REG_ADDR);  // R5
  wire [7:0] rd_val = (acc_addr_q == hbis_pkg::MODE_REG_ADDR) ? {5'h00, mode_q} : regs_q[acc_addr_q];
  wire erom_last = (idx_q == 8'(EPROM_WORDS - 1));
  wire [7:0] rd_lat = last_wr_q ? 8'(hbis_pkg::RD_WR_CYC) : 8'(hbis_pkg::RD_RD_CYC);  // R12

  // Edge history; data one cycle back is the last value seen inside select
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_prev_q <= 1'b1;
      dat_prev_q <= 8'h00;
    end else begin
      sel_prev_q <= sel_s;
      dat_prev_q <= dat_s;
    end
  end

  // Register store, written by the boot load or by host writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 128; i++) begin
        regs_q[i] <= hbis_pkg::MODE_RST;
      end
    end else if (wr_en) begin
      regs_q[wr_addr] <= wr_data;
    end
  end

  // Write report to the device core
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_wr   <= 1'b0;
      cfg_addr <= 7'h00;
      cfg_data <= 8'h00;
    end else begin
      cfg_wr <= wr_en;
      if (wr_en) begin
        cfg_addr <= wr_addr;
        cfg_data <= wr_data;
      end
    end
  end

  // Main sequencer: strap capture, boot load, bus accesses
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q      <= S_STRAP;
      cnt_q     <= 8'h00;
      idx_q     <= 8'h00;
      mode_q    <= hbis_pkg::MODE_OFF;
      acc_addr_q <= 7'h00;
      acc_rd_q  <= 1'b0;
      last_wr_q <= 1'b0;
      ack_q     <= 1'b1;
      ack_oe_q  <= 1'b0;
      dout_q    <= 8'h00;
      dout_oe_q <= 1'b0;
      erd_q     <= 1'b0;
      boot_busy <= 1'b1;
    end else begin
      if (mode_wr) begin
        mode_q <= wr_data[2:0];  // R5
      end
      case (st_q)
        S_STRAP: begin
          // Straps are taken once; later pin changes are never looked at
          if (cnt_q >= 8'(hbis_pkg::STRAP_SYNC_CYC)) begin
            mode_q <= strap_s;  // R3
            cnt_q  <= 8'(EPROM_WAIT);
            if (strap_erom) begin
              erd_q <= 1'b1;  // R4
              st_q  <= S_EROM;
            end else begin
              boot_busy <= 1'b0;
              st_q      <= S_IDLE;
            end
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        S_EROM: begin
          // Wait restarts whenever the host takes the EPROM select away
          if (!egnt_s) begin
            cnt_q <= 8'(EPROM_WAIT);  // R6
          end else if (erom_wr) begin
            cnt_q <= 8'(EPROM_WAIT);
            idx_q <= idx_q + 8'h01;
            if (erom_last) begin
              erd_q     <= 1'b0;
              boot_busy <= 1'b0;
              st_q      <= S_IDLE;
            end
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        S_IDLE: begin
          if (take) begin
            acc_addr_q <= addr_s;
            acc_rd_q   <= (dir_s == hbis_pkg::DIR_READ);  // R7
            ack_q      <= 1'b1;
            ack_oe_q   <= 1'b1;
            cnt_q      <= (dir_s == hbis_pkg::DIR_READ) ? rd_lat : 8'(hbis_pkg::WR_ACK_CYC);
            st_q       <= S_LAT;
          end
        end
        S_LAT: begin
          if (sel_rise) begin
            // Aborted access: let go of everything
            ack_oe_q <= 1'b0;  // R14
            st_q     <= S_IDLE;
          end else if (lat_end) begin
            ack_q     <= 1'b0;  // R12
            dout_q    <= rd_val;
            dout_oe_q <= acc_rd_q;  // R14
            st_q      <= S_DONE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        S_DONE: begin
          if (sel_rise) begin
            ack_oe_q  <= 1'b0;  // R14
            dout_oe_q <= 1'b0;  // R14
            ack_q     <= 1'b1;
            last_wr_q <= !acc_rd_q;
            st_q      <= S_IDLE;
          end
        end
        default: st_q <= S_STRAP;
      endcase
    end
  end

  // Mode shown to the core; disabled and boot modes leave the bus dead
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode <= hbis_pkg::MODE_OFF;
    end else begin
      mode <= mode_live || (mode_q == hbis_pkg::MODE_EPROM) ? mode_q : hbis_pkg::MODE_OFF;  // R2
    end
  end

  assign bus.dev_data    = dout_q;
  assign bus.dev_data_oe = dout_oe_q;
  assign bus.ack_o       = ack_q;
  assign bus.ack_oe      = ack_oe_q;
  assign bus.eprom_rd    = erd_q;
  assign bus.eprom_addr  = idx_q[6:0];

endmodule

// ---- testbench/hbis_monitor.sv ----
// Concurrent checks on the host link between the host end and the device end.
// Assumes one clock and the synchronous active-low reset shared by both ends.
module hbis_monitor (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [6:0] addr,
  input wire logic       direction_select,
  input wire logic       select_n,
  input wire logic [7:0] host_data,
  input wire logic       host_data_oe,
  input wire logic       dev_data_oe,
  input wire logic       ack_o,
  input wire logic       ack_oe,
  input wire logic       transfer_ack,
  input wire logic [2:0] mode,
  input wire logic       eprom_rd
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Helper state
  logic sel_q;      // Select level one cycle ago
  logic last_wr_q;  // Last finished access was a write

  // Remember the kind of the access that just ended
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_q     <= 1'b1;
      last_wr_q <= 1'b1;
    end else begin
      sel_q <= select_n;
      if (select_n && !sel_q) begin
        last_wr_q <= (direction_select != hbis_pkg::DIR_READ);
      end
    end
  end

  // ==========================================================================
  // Assertions
  chk_ack_rises_first: assert property ($rose(ack_oe) |-> ack_o)
    else $error("acknowledge driven low at once");
  chk_addr_dir_held: assert property (!select_n && $past(!select_n) |-> $stable(direction_select) && $stable(addr))
    else $error("address or direction moved inside an access");
  chk_hold_until_ack: assert property ($rose(select_n) |-> $past(!transfer_ack))
    else $error("select ended before acknowledge fell");
  chk_write_gap_kept: assert property ($rose(select_n) && direction_select != hbis_pkg::DIR_READ |=> select_n [*4])
    else $error("gap after write too short");
  chk_read_gap_kept: assert property ($rose(select_n) |=> select_n)
    else $error("gap between reads too short");
  chk_read_fast: assert property ($fell(select_n) && direction_select == hbis_pkg::DIR_READ && !last_wr_q
                                  && mode == hbis_pkg::MODE_PAR_A |-> ##[1:4] (!transfer_ack && dev_data_oe))
    else $error("read after read answered late");
  chk_read_slow: assert property ($fell(select_n) && direction_select == hbis_pkg::DIR_READ && last_wr_q
                                  && mode == hbis_pkg::MODE_PAR_A |-> ##[1:7] (!transfer_ack && dev_data_oe))
    else $error("read after write answered late");
  chk_wdata_held: assert property (!select_n && $past(!select_n) && direction_select != hbis_pkg::DIR_READ
                                   |-> host_data_oe && $stable(host_data))
    else $error("write data not held");
  chk_data_only_read: assert property (dev_data_oe && !select_n |-> direction_select == hbis_pkg::DIR_READ)
    else $error("device drove data in a write");
  chk_release_after: assert property (select_n [*4] |-> !ack_oe && !dev_data_oe)
    else $error("device still drives after select");
  chk_quiet_booting: assert property (eprom_rd |-> !ack_oe && !dev_data_oe)
    else $error("device answered the bus while booting");
endmodule

// ---- testbench/host_bus_interface_select_bench.sv ----
// Bench for the host link: host end and device end joined by hbis_if.
// Assumes the package, the interface and both ends are compiled first.
`define HBIS_CHECK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end

module host_bus_interface_select_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Stimulus table
  typedef struct packed {
    logic       wr;   // High for a write
    logic [6:0] a;    // Register address
    logic [7:0] d;    // Write data
    logic [7:0] exp;  // Expected response data
  } hbis_row_s;

  localparam int        SKEW = 1;  // Drive delay after the rising edge
  localparam hbis_row_s ROWS [7] = '{'{1'b1, 7'h10, 8'ha5, 8'ha5}, '{1'b0, 7'h10, 8'h00, 8'ha5},
                                     '{1'b0, 7'h10, 8'h00, 8'ha5}, '{1'b1, 7'h00, 8'h3c, 8'h3c},
                                     '{1'b0, 7'h00, 8'h00, 8'h3c}, '{1'b1, 7'h7f, 8'h04, 8'h04},
                                     '{1'b0, 7'h7f, 8'h00, 8'h04}};
  localparam logic [2:0] MODE_EXP [8] = '{hbis_pkg::MODE_OFF, hbis_pkg::MODE_EPROM, hbis_pkg::MODE_MUX,
                                          hbis_pkg::MODE_PAR_B, hbis_pkg::MODE_PAR_A, hbis_pkg::MODE_SERIAL,
                                          hbis_pkg::MODE_OFF, hbis_pkg::MODE_OFF};

  // ==========================================================================
  // Signals
  logic       clk;
  logic       rst_n;
  logic [2:0] straps;
  logic       req_valid;
  logic       req_write;
  logic [6:0] req_addr;
  logic [7:0] req_wdata;
  logic [7:0] rom_data;
  logic       req_ready;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic [6:0] rom_addr;
  logic [2:0] mode;
  logic       boot_busy;
  logic       cfg_wr;
  logic       rom_rd;
  logic [6:0] cfg_addr;
  logic [7:0] cfg_data;
  int         error_cnt = 0;
  int         compares = 0;

  // Boot image: word 7F enables the parallel bus, others are index-derived
  assign rom_data = (rom_addr == 7'h7f) ? 8'h04 : ({1'b0, rom_addr} ^ 8'h5a);

  // ==========================================================================
  // Instances
  hbis_if link_if ();

  hbis_host hbis_host_inst (
    .clk(clk), .rst_n(rst_n), .bus(link_if), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .rom_data(rom_data), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rom_addr(rom_addr), .rom_rd(rom_rd)
  );

  hbis_dev #(.EPROM_WORDS(128), .EPROM_WAIT(8)) hbis_dev_inst (
    .clk(clk), .rst_n(rst_n), .bus(link_if), .host_mode_straps(straps), .mode(mode),
    .boot_busy(boot_busy), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_data(cfg_data)
  );

  hbis_monitor hbis_monitor_inst (
    .clk(clk), .rst_n(rst_n), .addr(link_if.addr), .direction_select(link_if.direction_select),
    .select_n(link_if.select_n), .host_data(link_if.host_data), .host_data_oe(link_if.host_data_oe),
    .dev_data_oe(link_if.dev_data_oe), .ack_o(link_if.ack_o), .ack_oe(link_if.ack_oe),
    .transfer_ack(link_if.transfer_ack), .eprom_rd(link_if.eprom_rd), .mode(mode)
  );

  // ==========================================================================
  // Tasks
  // Verdict and end of run
  task automatic finish_test();
    if (error_cnt == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Advance to just after the next rising edge
  task automatic step();
    @(posedge clk);
    #SKEW;
  endtask

  // Hold reset with the given straps, then release it
  task automatic do_reset(input logic [2:0] s);
    rst_n = 1'b0;
    straps = s;
    repeat (20) step();
    rst_n = 1'b1;
  endtask

  // Wait a bounded time for the device to leave boot
  task automatic wait_boot();
    int n = 0;
    while (boot_busy !== 1'b0 && n < 4000) begin
      step();
      n++;
    end
    repeat (2) step();
    `HBIS_CHECK(boot_busy, 1'b0)
  endtask

  // One host access; ok stays low if no response comes within limit
  task automatic access(input logic wr, input logic [6:0] a, input logic [7:0] d, input int limit,
                        output logic [7:0] rd, output logic ok);
    int n = 0;
    ok = 1'b0;
    rd = 8'h00;
    while (req_ready !== 1'b1 && n < limit) begin
      step();
      n++;
    end
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    step();
    req_valid = 1'b0;
    while (!ok && n < limit) begin
      step();
      n++;
      if (rsp_valid === 1'b1) begin
        ok = 1'b1;
        rd = rsp_data;
      end
    end
  endtask

  // ==========================================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #(hbis_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
  end

  // Cuts a hang short well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    finish_test();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [7:0] rd;
    logic       ok;
    rst_n = 1'b0;
    straps = hbis_pkg::MODE_PAR_A;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 7'h00;
    req_wdata = 8'h00;
    repeat (20) step();
    `HBIS_CHECK({link_if.ack_oe, link_if.dev_data_oe, boot_busy, link_if.select_n}, 4'h3)
    rst_n = 1'b1;
    wait_boot();
    `HBIS_CHECK(mode, hbis_pkg::MODE_PAR_A)
    // Table of ordinary accesses, back to back
    foreach (ROWS[i]) begin
      access(ROWS[i].wr, ROWS[i].a, ROWS[i].d, 60, rd, ok);
      `HBIS_CHECK(ok, 1'b1)
      `HBIS_CHECK(rd, ROWS[i].exp)
      if (ROWS[i].wr) begin
        repeat (3) step();
        `HBIS_CHECK({cfg_wr, cfg_addr, cfg_data}, {1'b1, ROWS[i].a, ROWS[i].d})
      end
    end
    // Straps moved after capture are ignored
    straps = hbis_pkg::MODE_SERIAL;
    repeat (10) step();
    `HBIS_CHECK(mode, hbis_pkg::MODE_PAR_A)
    // Software switches the port off, then the bus is ignored
    access(1'b1, hbis_pkg::MODE_REG_ADDR, 8'h00, 60, rd, ok);
    repeat (4) step();
    `HBIS_CHECK(mode, hbis_pkg::MODE_OFF)
    access(1'b0, 7'h10, 8'h00, 40, rd, ok);
    `HBIS_CHECK(ok, 1'b0)
    `HBIS_CHECK(link_if.ack_oe, 1'b0)
    // Every strap code, the boot load among them
    for (int c = 0; c < 8; c++) begin
      do_reset(c[2:0]);
      if (c == 1) begin
        repeat (6) step();
        `HBIS_CHECK({mode, rom_rd}, {hbis_pkg::MODE_EPROM, 1'b1})
        wait_boot();
        `HBIS_CHECK(mode, hbis_pkg::MODE_PAR_A)
        access(1'b0, 7'h03, 8'h00, 60, rd, ok);
        `HBIS_CHECK(rd, 8'h59)
      end else begin
        wait_boot();
        `HBIS_CHECK(mode, MODE_EXP[c])
      end
    end
    finish_test();
  end
endmodule
